// >>> logic/asr_defines.vh
// Purpose: Shared constants of the asynchronous serial receiver.
// Assumes: Included by bare name from every design file.
// Notes: Register indices are word indices; byte address is four times the index.
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH

// Register word indices
`define ASR_IDX_PERIPHERAL_FLAG 8'h0c
`define ASR_IDX_RECEIVE_STATUS 8'h18
`define ASR_IDX_RECEIVE_DATA 8'h1a
`define ASR_IDX_PERIPHERAL_ENABLE 8'h8c
`define ASR_IDX_TRANSMIT_STATUS 8'h98
`define ASR_IDX_BAUD_DIVISOR 8'h99

// Peripheral flag and enable register fields
`define ASR_BIT_RECEIVE_FLAG 5

// Receive status and control fields
`define ASR_BIT_SERIAL_PORT_ENABLE 7
`define ASR_BIT_NINTH_BIT_ENABLE 6
`define ASR_BIT_CONT_RECEIVE_ENABLE 4
`define ASR_BIT_FRAMING_ERROR 2
`define ASR_BIT_OVERRUN_ERROR 1
`define ASR_BIT_RECEIVED_NINTH 0

// Transmit status and control fields
`define ASR_BIT_CLOCK_SOURCE 7
`define ASR_BIT_TX_NINE 6
`define ASR_BIT_TX_ENABLE 5
`define ASR_BIT_CLOCKED_MODE 4
`define ASR_BIT_HIGH_SPEED_BAUD 2
`define ASR_BIT_SHIFTER_EMPTY 1
`define ASR_BIT_TX_NINTH 0

// Reset values
`define ASR_RST_PERIPHERAL_FLAG 8'h00
`define ASR_RST_RECEIVE_STATUS 8'h00
`define ASR_RST_RECEIVE_DATA 8'h00
`define ASR_RST_PERIPHERAL_ENABLE 8'h00
`define ASR_RST_TRANSMIT_STATUS 8'h02
`define ASR_RST_BAUD_DIVISOR 8'h00

// Writable masks of the control registers
`define ASR_WMASK_RECEIVE_STATUS 8'hd0
`define ASR_WMASK_TRANSMIT_STATUS 8'hf5
`define ASR_WMASK_ENABLE 8'h20

// Timing counts in clock or tick units
`define ASR_LOW_SPEED_PRESCALE 2'h3
`define ASR_OVERSAMPLE_LAST 4'hf
`define ASR_VOTE_FIRST 4'h7
`define ASR_VOTE_LAST 4'h9
`define ASR_EVAL_PHASE 4'ha
`define ASR_BITS_NARROW 4'h8
`define ASR_BITS_WIDE 4'h9

`endif

// >>> logic/asr_baud_gen.v
// Purpose: Oversampling tick generator for the receiver bit clock.
// Assumes: One tick is one-sixteenth of a bit time.
// Notes: High speed ticks every divisor+1 clocks; low speed every 4*(divisor+1).
`timescale 1ns/1ns
`include "asr_defines.vh"
module asr_baud_gen
(
	input wire mclk,
	input wire resetn,
	input wire run,
	input wire high_speed,
	input wire [7:0] divisor,
	output reg tick
);
	reg [7:0] count_reg;
	reg [1:0] pre_reg;

	// Divider held at zero while the receiver is idle or disabled
	always @(posedge mclk)
	begin
		if (!resetn || !run)
		begin
			count_reg <= 8'h00;
			pre_reg <= 2'h0;
			tick <= 1'b0;
		end
		else if (count_reg == divisor)
		begin
			count_reg <= 8'h00;
			if (high_speed || pre_reg == `ASR_LOW_SPEED_PRESCALE)
			begin
				pre_reg <= 2'h0;
				tick <= 1'b1;
			end
			else
			begin
				pre_reg <= pre_reg + 2'h1;
				tick <= 1'b0;
			end
		end
		else
		begin
			count_reg <= count_reg + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule // asr_baud_gen

// >>> logic/asr_bit_vote.v
// Purpose: Three-sample majority vote over the middle of each bit.
// Assumes: Phase counts ticks within a bit, zero at the bit start.
// Notes: Vote is stable from the tick after the last sample to the next bit.
`timescale 1ns/1ns
`include "asr_defines.vh"
module asr_bit_vote
(
	input wire mclk,
	input wire resetn,
	input wire tick,
	input wire [3:0] phase,
	input wire rx_level,
	output wire vote
);
	reg [2:0] samples_reg;

	// Majority of three
	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
		end
	endfunction

	// Sample the line at the three middle ticks
	always @(posedge mclk)
	begin
		if (!resetn)
			samples_reg <= 3'h7;
		else if (tick && phase >= `ASR_VOTE_FIRST && phase <= `ASR_VOTE_LAST)
			samples_reg <= {samples_reg[1:0], rx_level};
	end

	assign vote = maj3(samples_reg);
endmodule // asr_bit_vote

// >>> logic/asr_receiver.v
// Purpose: Asynchronous serial receiver with Wishbone register access.
// Assumes: Classic Wishbone slave, byte lane 0 carries each 8-bit register.
// Notes: Byte address of a register is four times its word index.
// Functional notes
// - Async mode runs when clocked-mode bit clear and serial port enable set.
// - Bit rate from baud divisor; high-speed select picks the faster range.
// - Ninth-bit enable makes frames nine data bits; ninth bit kept apart.
// - Frames accepted only while continuous receive enable is set.
// - Frame completion sets receive flag unless the frame overruns; interrupt only when enable bit set.
// - Ninth bit, framing and overrun errors readable in receive status register.
// - Eight data bits read from the receive data buffer register.
// - Clearing continuous receive enable clears latched receive errors.
// - Unimplemented bits of receive registers read as zero.
`timescale 1ns/1ns
`include "asr_defines.vh"
module asr_receiver
#(
	parameter ADR_W = 10
)
(
	input wire mclk,
	input wire resetn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire rx_pin,
	output wire serial_pins_claimed,
	output wire tx_pin,
	output wire tx_pin_oe,
	output wire irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_STOP = 2'h3;

	// Control registers
	reg serial_port_enable_reg;
	reg ninth_bit_receive_enable_reg;
	reg continuous_receive_enable_reg;
	reg [7:0] transmit_ctrl_reg;
	reg [7:0] baud_divisor_reg;
	reg receive_interrupt_enable_reg;
	// Status and data
	reg receive_interrupt_flag_reg;
	reg framing_error_flag_reg;
	reg overrun_error_flag_reg;
	reg received_ninth_bit_reg;
	reg [7:0] receive_data_buffer_reg;
	reg buffer_full_reg;
	// Receiver engine
	reg [1:0] state_reg;
	reg [3:0] phase_reg;
	reg [3:0] bit_count_reg;
	reg [8:0] shift_reg;
	reg rx_level_reg;
	reg frame_done_reg;
	reg frame_stop_reg;
	reg [8:0] frame_bits_reg;
	reg frame_nine_reg;

	wire tick;
	wire vote;
	wire bus_req;
	wire bus_write;
	wire bus_read;
	wire [7:0] bus_index;
	wire async_mode;
	wire receive_run;
	wire eval_now;
	wire data_read;
	wire flag_clear;
	wire [3:0] frame_bits;
	reg [7:0] read_byte;

	// Word index from a byte address; misaligned addresses map nowhere
	function [7:0] word_index;
		input [ADR_W-1:0] adr;
		begin
			if (adr[1:0] != 2'h0)
				word_index = 8'hff;
			else
				word_index = adr[9:2];
		end
	endfunction

	// Bus request decode; one access per request, answered next cycle
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_write = bus_req && wb_we_i && wb_sel_i[0];
	assign bus_read = bus_req && !wb_we_i;
	assign bus_index = word_index(wb_adr_i);

	// Mode and run conditions
	assign async_mode = serial_port_enable_reg && !transmit_ctrl_reg[`ASR_BIT_CLOCKED_MODE];
	assign receive_run = async_mode && continuous_receive_enable_reg && !overrun_error_flag_reg;
	assign serial_pins_claimed = async_mode;
	// Transmitter absent: line held idle high while the port owns the pin
	assign tx_pin = 1'b1;
	assign tx_pin_oe = async_mode;

	assign frame_bits = ninth_bit_receive_enable_reg ? `ASR_BITS_WIDE : `ASR_BITS_NARROW;
	assign eval_now = tick && phase_reg == `ASR_EVAL_PHASE;
	assign data_read = bus_read && bus_index == `ASR_IDX_RECEIVE_DATA;
	assign flag_clear = bus_write && bus_index == `ASR_IDX_PERIPHERAL_FLAG && wb_dat_i[`ASR_BIT_RECEIVE_FLAG];

	// Interrupt output: sticky flag masked by the receive interrupt enable bit
	assign irq = receive_interrupt_flag_reg && receive_interrupt_enable_reg;

	// Bit clock divider
	asr_baud_gen u_baud
	(
		.mclk(mclk),
		.resetn(resetn),
		.run(receive_run && state_reg != ST_IDLE),
		.high_speed(transmit_ctrl_reg[`ASR_BIT_HIGH_SPEED_BAUD]),
		.divisor(baud_divisor_reg),
		.tick(tick)
	);

	// Mid-bit majority sampler
	asr_bit_vote u_vote
	(
		.mclk(mclk),
		.resetn(resetn),
		.tick(tick),
		.phase(phase_reg),
		.rx_level(rx_level_reg),
		.vote(vote)
	);

	// Line register
	always @(posedge mclk)
	begin
		if (!resetn)
			rx_level_reg <= 1'b1;
		else
			rx_level_reg <= rx_pin;
	end

	// Frame engine: start, data bits LSB first, stop
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			state_reg <= ST_IDLE;
			phase_reg <= 4'h0;
			bit_count_reg <= 4'h0;
			shift_reg <= 9'h000;
			frame_done_reg <= 1'b0;
			frame_stop_reg <= 1'b1;
			frame_bits_reg <= 9'h000;
			frame_nine_reg <= 1'b0;
		end
		else
		begin
			frame_done_reg <= 1'b0;
			if (!receive_run)
			begin
				state_reg <= ST_IDLE;
				phase_reg <= 4'h0;
			end
			else
			begin
				if (tick)
					phase_reg <= phase_reg + 4'h1;
				case (state_reg)
					ST_IDLE:
					begin
						phase_reg <= 4'h0;
						if (!rx_level_reg)
							state_reg <= ST_START;
					end
					ST_START:
					begin
						if (eval_now)
						begin
							// A high vote is a glitch, not a start bit
							if (vote)
								state_reg <= ST_IDLE;
							else
							begin
								state_reg <= ST_DATA;
								bit_count_reg <= 4'h0;
								shift_reg <= 9'h000;
							end
						end
					end
					ST_DATA:
					begin
						if (eval_now)
						begin
							shift_reg <= {vote, shift_reg[8:1]};
							bit_count_reg <= bit_count_reg + 4'h1;
							if (bit_count_reg == frame_bits - 4'h1)
								state_reg <= ST_STOP;
						end
					end
					ST_STOP:
					begin
						if (eval_now)
						begin
							state_reg <= ST_IDLE;
							frame_done_reg <= 1'b1;
							frame_stop_reg <= vote;
							frame_bits_reg <= shift_reg;
							frame_nine_reg <= ninth_bit_receive_enable_reg;
						end
					end
					default:
						state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// Receive buffer, ninth bit and error flags
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			receive_data_buffer_reg <= `ASR_RST_RECEIVE_DATA;
			received_ninth_bit_reg <= 1'b0;
			framing_error_flag_reg <= 1'b0;
			overrun_error_flag_reg <= 1'b0;
			buffer_full_reg <= 1'b0;
		end
		else
		begin
			if (data_read)
				buffer_full_reg <= 1'b0;
			if (frame_done_reg)
			begin
				if (buffer_full_reg && !data_read)
					overrun_error_flag_reg <= 1'b1;
				else
				begin
					buffer_full_reg <= 1'b1;
					// Narrow frames arrive left-aligned in the shifter
					if (frame_nine_reg)
					begin
						receive_data_buffer_reg <= frame_bits_reg[7:0];
						received_ninth_bit_reg <= frame_bits_reg[8];
					end
					else
					begin
						receive_data_buffer_reg <= frame_bits_reg[8:1];
						received_ninth_bit_reg <= 1'b0;
					end
					framing_error_flag_reg <= !frame_stop_reg;
				end
			end
			if (!continuous_receive_enable_reg)
			begin
				framing_error_flag_reg <= 1'b0;
				overrun_error_flag_reg <= 1'b0;
			end
		end
	end

	// Receive flag: set by a stored frame, cleared by writing one; set wins
	always @(posedge mclk)
	begin
		if (!resetn)
			receive_interrupt_flag_reg <= 1'b0;
		else if (frame_done_reg && !(buffer_full_reg && !data_read))
			receive_interrupt_flag_reg <= 1'b1;
		else if (flag_clear)
			receive_interrupt_flag_reg <= 1'b0;
	end

	// Software writes to control registers
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			serial_port_enable_reg <= 1'b0;
			ninth_bit_receive_enable_reg <= 1'b0;
			continuous_receive_enable_reg <= 1'b0;
			transmit_ctrl_reg <= `ASR_RST_TRANSMIT_STATUS & `ASR_WMASK_TRANSMIT_STATUS;
			baud_divisor_reg <= `ASR_RST_BAUD_DIVISOR;
			receive_interrupt_enable_reg <= 1'b0;
		end
		else if (bus_write)
		begin
			case (bus_index)
				`ASR_IDX_RECEIVE_STATUS:
				begin
					serial_port_enable_reg <= wb_dat_i[`ASR_BIT_SERIAL_PORT_ENABLE];
					ninth_bit_receive_enable_reg <= wb_dat_i[`ASR_BIT_NINTH_BIT_ENABLE];
					continuous_receive_enable_reg <= wb_dat_i[`ASR_BIT_CONT_RECEIVE_ENABLE];
				end
				`ASR_IDX_TRANSMIT_STATUS:
					transmit_ctrl_reg <= wb_dat_i[7:0] & `ASR_WMASK_TRANSMIT_STATUS;
				`ASR_IDX_BAUD_DIVISOR:
					baud_divisor_reg <= wb_dat_i[7:0];
				`ASR_IDX_PERIPHERAL_ENABLE:
					receive_interrupt_enable_reg <= wb_dat_i[`ASR_BIT_RECEIVE_FLAG];
				default:
					baud_divisor_reg <= baud_divisor_reg;
			endcase
		end
	end

	// Read multiplexer; unused bit positions and unmapped words read zero
	always @*
	begin
		read_byte = 8'h00;
		case (bus_index)
			`ASR_IDX_PERIPHERAL_FLAG:
				read_byte[`ASR_BIT_RECEIVE_FLAG] = receive_interrupt_flag_reg;
			`ASR_IDX_RECEIVE_STATUS:
			begin
				read_byte[`ASR_BIT_SERIAL_PORT_ENABLE] = serial_port_enable_reg;
				read_byte[`ASR_BIT_NINTH_BIT_ENABLE] = ninth_bit_receive_enable_reg;
				read_byte[`ASR_BIT_CONT_RECEIVE_ENABLE] = continuous_receive_enable_reg;
				read_byte[`ASR_BIT_FRAMING_ERROR] = framing_error_flag_reg;
				read_byte[`ASR_BIT_OVERRUN_ERROR] = overrun_error_flag_reg;
				read_byte[`ASR_BIT_RECEIVED_NINTH] = received_ninth_bit_reg;
			end
			`ASR_IDX_RECEIVE_DATA:
				read_byte = receive_data_buffer_reg;
			`ASR_IDX_PERIPHERAL_ENABLE:
				read_byte[`ASR_BIT_RECEIVE_FLAG] = receive_interrupt_enable_reg;
			`ASR_IDX_TRANSMIT_STATUS:
			begin
				read_byte = transmit_ctrl_reg;
				// Transmit shifter is always empty in this receive-only block
				read_byte[`ASR_BIT_SHIFTER_EMPTY] = 1'b1;
			end
			`ASR_IDX_BAUD_DIVISOR:
				read_byte = baud_divisor_reg;
			default:
				read_byte = 8'h00;
		endcase
	end

	// Bus answer: ack one cycle after the request, data registered with it
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_read)
				wb_dat_o <= {24'h000000, read_byte};
			else
				wb_dat_o <= 32'h00000000;
		end
	end
endmodule // asr_receiver

// >>> verif/asr_receiver_monitor.sv
// Purpose: Port checker for the serial receiver.
// Assumes: Classic single-cycle bus master.
// Notes: Shadows a few control bits from bus writes.
`timescale 1ns/1ns
module asr_receiver_monitor
#(
	parameter ADR_W = 10
)
(
	input wire mclk,
	input wire resetn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire rx_pin,
	input wire serial_pins_claimed,
	input wire tx_pin,
	input wire tx_pin_oe,
	input wire irq
);
	logic wr_tk;
	logic irq_wr;
	logic port_en_reg;
	logic sync_reg;
	logic ena_reg;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Write taken at this edge
	assign wr_tk = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
	// Write to the flag or enable register, the only ways irq may drop
	assign irq_wr = wr_tk && (wb_adr_i == 10'h030 || wb_adr_i == 10'h230);
	// Shadow of the control bits software wrote
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			port_en_reg <= 1'b0;
			sync_reg <= 1'b0;
			ena_reg <= 1'b0;
		end
		else if (wr_tk)
		begin
			if (wb_adr_i == 10'h060)
				port_en_reg <= wb_dat_i[7];
			if (wb_adr_i == 10'h260)
				sync_reg <= wb_dat_i[4];
			if (wb_adr_i == 10'h230)
				ena_reg <= wb_dat_i[5];
		end
	end
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_status_gaps: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 10'h060) |-> !wb_dat_o[5] && !wb_dat_o[3])
		else $error("unused status bits not zero");
	a_tx_idle: assert property (tx_pin && tx_pin_oe == serial_pins_claimed)
		else $error("transmit pin state wrong");
	a_pins_claim: assert property (serial_pins_claimed == (port_en_reg && !sync_reg))
		else $error("pin claim does not follow mode bits");
	a_irq_enable: assert property (irq |-> ena_reg)
		else $error("interrupt while disabled");
	a_irq_clear: assert property ($fell(irq) |-> $past(irq_wr))
		else $error("interrupt fell without a write");
endmodule // asr_receiver_monitor
bind asr_receiver asr_receiver_monitor #(.ADR_W(ADR_W)) u_mon (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_pin(rx_pin), .serial_pins_claimed(serial_pins_claimed),
	.tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .irq(irq));

// >>> verif/asr_remote_tx.sv
// Purpose: Remote serial transmitter model.
// Assumes: Line idles high; bit time given in clocks.
// Notes: Stop level is chosen per frame to make framing faults.
`timescale 1ns/1ns
module asr_remote_tx
(
	input wire mclk,
	output logic line
);
	initial line = 1'b1;
	// Start bit, data LSB first, stop bit, then two idle bit times
	task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bt);
		@(posedge mclk);
		for (int i = 0; i < nb + 2; i++)
		begin
			line <= (i == 0) ? 1'b0 : (i <= nb) ? d[i - 1] : stp;
			repeat (bt) @(posedge mclk);
		end
		line <= 1'b1;
		repeat (2 * bt) @(posedge mclk);
	endtask
endmodule // asr_remote_tx

// >>> verif/asr_receiver_tb.sv
// Purpose: Self-checking bench of the serial receiver.
// Assumes: One-cycle bus answer, 16 or 128 clocks per bit.
// Notes: Read answers are checked against a queue of notes.
`timescale 1ns/1ns
module asr_receiver_tb;
	logic mclk;
	logic resetn;
	logic wb_cyc_i, wb_stb_i, wb_we_i, nb9, stp;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [7:0] d1, d2;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, rx_line, pins, tx_pin, tx_oe, irq;
	logic [31:0] exp_q[$];
	logic [9:0] adrs[8] = '{10'h030, 10'h060, 10'h068, 10'h230, 10'h260, 10'h264, 10'h004, 10'h061};
	logic [7:0] rstv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
	int n_fail = 0;
	int checks_done = 0;
	int cyc_n = 0;
	asr_receiver #(.ADR_W(10)) dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_pin(rx_line), .serial_pins_claimed(pins), .tx_pin(tx_pin), .tx_pin_oe(tx_oe),
		.irq(irq));
	asr_remote_tx rtx (.mclk(mclk), .line(rx_line));
	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One classic bus cycle, held until ack is sampled
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		// Wait for the answer; the hang guard ends the run if ack never comes
		do
			@(posedge mclk);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask
	// Each read answer is compared with the oldest note
	always @(posedge mclk)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hffffffff);
	// Hang guard
	always @(posedge mclk)
	begin
		cyc_n++;
		if (cyc_n == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end
	// Main sequence
	initial
	begin
		resetn = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 10'h0;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		void'($urandom(811));
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(adrs[i], rstv[i]);
		$display("Test reset values done");
		wr(10'h260, 8'h04);
		rd(10'h260, 8'h06);
		wr(10'h264, 8'h00);
		wr(10'h230, 8'h20);
		wr(10'h060, 8'hff);
		rd(10'h060, 8'hd0);
		check({31'h0, pins}, 32'h1);
		check({30'h0, tx_pin, tx_oe}, 32'h3);
		wr(10'h060, 8'h90);
		d1 = 8'($urandom);
		rtx.send({1'b0, d1}, 8, 1'b1, 16);
		rd(10'h030, 8'h20);
		check({31'h0, irq}, 32'h1);
		rd(10'h060, 8'h90);
		rd(10'h068, d1);
		wr(10'h030, 8'h20);
		rd(10'h030, 8'h00);
		$display("Test eight-bit frame done");
		wr(10'h060, 8'hd0);
		for (int k = 0; k < 3; k++)
		begin
			nb9 = (k == 0);
			stp = (k != 2);
			d1 = 8'($urandom);
			rtx.send({nb9, d1}, 9, stp, 16);
			rd(10'h060, {4'hd, 1'b0, !stp, 1'b0, nb9});
			rd(10'h068, d1);
			wr(10'h030, 8'h20);
		end
		wr(10'h060, 8'hc0);
		rd(10'h060, 8'hc0);
		$display("Test nine-bit and framing done");
		wr(10'h060, 8'h90);
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		rtx.send({1'b0, d1}, 8, 1'b1, 16);
		rtx.send({1'b0, d2}, 8, 1'b1, 16);
		rd(10'h060, 8'h92);
		rd(10'h068, d1);
		wr(10'h060, 8'h80);
		rd(10'h060, 8'h80);
		wr(10'h030, 8'h20);
		rtx.send({1'b0, d2}, 8, 1'b1, 16);
		rd(10'h030, 8'h00);
		$display("Test overrun and disable done");
		wr(10'h230, 8'h00);
		wr(10'h260, 8'h00);
		wr(10'h264, 8'h01);
		wr(10'h060, 8'h90);
		rtx.send({1'b0, d2}, 8, 1'b1, 128);
		rd(10'h030, 8'h20);
		check({31'h0, irq}, 32'h0);
		rd(10'h068, d2);
		wr(10'h260, 8'h10);
		check({31'h0, pins}, 32'h0);
		check({30'h0, tx_pin, tx_oe}, 32'h2);
		$display("Test low speed and mode done");
		finish_test();
	end
endmodule // asr_receiver_tb
